// >>> verilog/nvc_pkg.sv
// Purpose: Shared constants and types for the memory controller registers
// Assumes: Byte-wide register port with 4-bit offsets
// Notes: Offsets, bit positions and reset values live only here
package nvc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OFF_NVM_COMMAND = 4'h0;
  localparam logic [3:0] OFF_SECTION_PROTECTION = 4'h1;
  localparam logic [3:0] OFF_NVM_STATE = 4'h2;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h3;
  localparam logic [3:0] OFF_IRQ_PENDING = 4'h4;
  localparam logic [3:0] OFF_FUSE_VALUE_LO = 4'h6;
  localparam logic [3:0] OFF_FUSE_VALUE_HI = 4'h7;
  localparam logic [3:0] OFF_LAST_LOC_LO = 4'h8;
  localparam logic [3:0] OFF_LAST_LOC_HI = 4'h9;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_APP_WP = 0;
  localparam int BIT_BOOT_LOCK = 1;
  localparam int BIT_FLASH_BUSY = 0;
  localparam int BIT_EEPROM_BUSY = 1;
  localparam int BIT_WRITE_FAULT = 2;
  localparam int BIT_EEPROM_IDLE = 0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ----------------------------------------
  // Commands and states
  // ----------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_PAGE_WRITE = 3'h1,
    CMD_PAGE_ERASE = 3'h2,
    CMD_PAGE_ERASE_PROGRAM = 3'h3,
    CMD_BUFFER_CLEAR = 3'h4,
    CMD_FULL_ERASE = 3'h5,
    CMD_EEPROM_FULL_ERASE = 3'h6,
    CMD_FUSE_PROGRAM = 3'h7
  } nvc_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LAUNCH = 3'b010,
    ST_RUN = 3'b100
  } nvc_st_t;
  typedef struct packed {
    logic [15:0] value;
  } nvc_word_state_t;
  typedef struct packed {
    nvc_st_t st;
    nvc_cmd_t cmd;
    logic boot_lock;
    logic lock_active;
    logic app_wp;
    logic fault;
    logic irq_en;
    logic irq_flag;
    logic [7:0] rdata;
    logic start;
    logic target_eeprom;
    logic erase_eeprom;
    logic guard_valid;
    logic [15:0] guard_data;
  } nvc_state_t;
endpackage

// >>> verilog/nvc_word_if.sv
// Purpose: Carrier between the controller and a 16-bit byte-pair register
// Assumes: One controller, one storage end
// Notes: Hardware load wins over a byte write in the same cycle
`timescale 1ns/1ps
`default_nettype none
interface nvc_word_if;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wbyte;
  logic load;
  logic [15:0] load_val;
  logic [15:0] value;
  modport ctrl (output wr_lo, output wr_hi, output wbyte, output load, output load_val, input value);
  modport store (input wr_lo, input wr_hi, input wbyte, input load, input load_val, output value);
endinterface
`default_nettype wire

// >>> verilog/nvc_word_reg.sv
// Purpose: 16-bit register written as two bytes or loaded whole
// Assumes: Strobes from logic on core_clk
// Notes: Low byte at the base offset, high byte one above
`timescale 1ns/1ps
`default_nettype none
module nvc_word_reg
  import nvc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Controller side
  nvc_word_if.store port
);
  nvc_word_state_t s_q;
  nvc_word_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (port.load)
    begin
      s_d.value = port.load_val;
    end
    else
    begin
      if (port.wr_lo)
      begin
        s_d.value[7:0] = port.wbyte;
      end
      if (port.wr_hi)
      begin
        s_d.value[15:8] = port.wbyte;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_q.value <= RST_WORD;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign port.value = s_q.value;
endmodule
`default_nettype wire

// >>> verilog/nvc_regs.sv
// Purpose: Register file and command launch of the nonvolatile memory controller
// Assumes: All inputs come from logic on core_clk; array timing lives elsewhere
// Notes: Read data stand in the cycle after the read strobe, zero otherwise
`timescale 1ns/1ps
`default_nettype none
module nvc_regs
  import nvc_pkg::*;
#(
  parameter logic [15:0] EEPROM_BASE = 16'h1400,
  parameter logic [15:0] EEPROM_END = 16'h14ff,
  parameter logic [15:0] FLASH_BASE = 16'h8000,
  parameter logic [15:0] BOOT_END = 16'h81ff,
  parameter logic [15:0] APP_END = 16'h8fff
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Access context of the current write
  input wire logic from_debug_port,
  input wire logic self_program_key,
  input wire logic change_protection_unlock,
  input wire logic exec_in_boot,
  // Memory array side
  input wire logic flash_busy,
  input wire logic eeprom_busy,
  input wire logic buffer_fill,
  input wire logic [15:0] buffer_fill_addr,
  input wire logic buffer_section_mix,
  input wire logic eeprom_preserve_fuse,
  output logic nvm_start,
  output logic [2:0] nvm_cmd,
  output logic nvm_target_eeprom,
  output logic nvm_erase_eeprom,
  output logic [15:0] fuse_addr,
  output logic [15:0] fuse_data,
  // Memory read guard
  input wire logic mem_rd_valid,
  input wire logic [15:0] mem_rd_addr,
  input wire logic [15:0] mem_rd_data,
  output logic guard_rd_valid,
  output logic [15:0] guard_rd_data,
  // Interrupt request
  output logic eeprom_idle_irq
);
  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (EEPROM_END < EEPROM_BASE || BOOT_END < FLASH_BASE || APP_END < BOOT_END)
  begin : g_bad_map
    $error("nvc_regs: memory map bounds out of order");
  end

  // ----------------------------------------
  // Byte-pair words
  // ----------------------------------------
  nvc_word_if fuse_value_if ();
  nvc_word_if last_loc_if ();

  nvc_word_reg u_fuse_value (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .port(fuse_value_if.store)
  );

  nvc_word_reg u_last_loc (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .port(last_loc_if.store)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  nvc_state_t s_q;
  nvc_state_t s_d;
  logic [15:0] loc;
  logic loc_eeprom;
  logic loc_app;
  logic fill_app;
  logic rd_boot;
  logic any_busy;
  logic wr_cmd;
  logic wr_prot;
  logic wr_ien;
  logic wr_ipend;
  nvc_cmd_t code;
  logic code_page;
  logic code_ok;
  logic code_fault;

  assign loc = last_loc_if.value;
  // Command region tests use the last updated location, so a buffer fill retargets the next command; fill and read tests use their own addresses
  assign loc_eeprom = (loc >= EEPROM_BASE) && (loc <= EEPROM_END);
  assign loc_app = (loc > BOOT_END) && (loc <= APP_END);
  assign fill_app = (buffer_fill_addr > BOOT_END) && (buffer_fill_addr <= APP_END);
  assign rd_boot = (mem_rd_addr >= FLASH_BASE) && (mem_rd_addr <= BOOT_END);
  assign any_busy = flash_busy || eeprom_busy;
  assign wr_cmd = reg_wr && (reg_addr == OFF_NVM_COMMAND);
  assign wr_prot = reg_wr && (reg_addr == OFF_SECTION_PROTECTION);
  assign wr_ien = reg_wr && (reg_addr == OFF_IRQ_ENABLE);
  assign wr_ipend = reg_wr && (reg_addr == OFF_IRQ_PENDING);
  assign code = nvc_cmd_t'(reg_wdata[2:0]);
  assign code_page = (code == CMD_PAGE_WRITE) || (code == CMD_PAGE_ERASE) || (code == CMD_PAGE_ERASE_PROGRAM);

  // Fuse programming is refused from the CPU side
  assign code_ok = (code != CMD_NONE) && ((code != CMD_FUSE_PROGRAM) || from_debug_port);

  // Page operations on a protected buffer fail, as do page write and erase-program on a mixed-section one
  assign code_fault = code_page && ((loc_app && s_q.app_wp) ||
                                    (buffer_section_mix && (code != CMD_PAGE_ERASE)));

  // ----------------------------------------
  // Word strobes
  // ----------------------------------------
  assign fuse_value_if.wr_lo = reg_wr && (reg_addr == OFF_FUSE_VALUE_LO);
  assign fuse_value_if.wr_hi = reg_wr && (reg_addr == OFF_FUSE_VALUE_HI);
  assign fuse_value_if.wbyte = reg_wdata;
  assign fuse_value_if.load = 1'b0;
  assign fuse_value_if.load_val = RST_WORD;

  // Buffer fills record the last updated location
  assign last_loc_if.wr_lo = reg_wr && (reg_addr == OFF_LAST_LOC_LO);
  assign last_loc_if.wr_hi = reg_wr && (reg_addr == OFF_LAST_LOC_HI);
  assign last_loc_if.wbyte = reg_wdata;
  assign last_loc_if.load = buffer_fill;
  assign last_loc_if.load_val = buffer_fill_addr;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.rdata = RST_BYTE;

    case (s_q.st)
      ST_IDLE:
      begin
        // A refused write leaves no trace except the fault bit
        if (wr_cmd && self_program_key && !any_busy && code_ok)
        begin
          if (code_fault)
          begin
            s_d.fault = 1'b1;
          end
          else
          begin
            s_d.fault = 1'b0;
            s_d.cmd = code;
            s_d.start = 1'b1;
            s_d.target_eeprom = code_page ? loc_eeprom : (code == CMD_EEPROM_FULL_ERASE);
            s_d.erase_eeprom = ((code == CMD_FULL_ERASE) && !eeprom_preserve_fuse) ||
                               (code == CMD_EEPROM_FULL_ERASE);
            s_d.st = ST_LAUNCH;
          end
        end
      end
      ST_LAUNCH:
      begin
        s_d.cmd = CMD_NONE;
        s_d.st = ST_RUN;
      end
      ST_RUN:
      begin
        // The array must raise busy right after launch, or the sequencer idles early
        if (!any_busy)
        begin
          s_d.st = ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
        s_d.cmd = CMD_NONE;
      end
    endcase

    // A fill into the protected application area is a write error
    if (buffer_fill && fill_app && s_q.app_wp)
    begin
      s_d.fault = 1'b1;
    end

    // Both protection bits only ever set; reset is the sole way back to zero
    if (wr_prot && change_protection_unlock)
    begin
      if (reg_wdata[BIT_APP_WP])
      begin
        s_d.app_wp = 1'b1;
      end
      if (reg_wdata[BIT_BOOT_LOCK] && exec_in_boot)
      begin
        s_d.boot_lock = 1'b1;
      end
    end

    // Boot code may finish its own work before the lock bites
    if (s_q.boot_lock && !exec_in_boot)
    begin
      s_d.lock_active = 1'b1;
    end

    if (wr_ien)
    begin
      s_d.irq_en = reg_wdata[BIT_EEPROM_IDLE];
    end

    // Idle sets the flag and beats a clear in the same cycle
    if (wr_ipend && reg_wdata[BIT_EEPROM_IDLE])
    begin
      s_d.irq_flag = 1'b0;
    end
    if (!eeprom_busy)
    begin
      s_d.irq_flag = 1'b1;
    end

    // Guarded read data trail the memory read by one cycle
    s_d.guard_valid = mem_rd_valid;
    s_d.guard_data = (rd_boot && s_q.lock_active) ? RST_WORD : mem_rd_data;

    if (reg_rd)
    begin
      case (reg_addr)
        OFF_NVM_COMMAND: s_d.rdata = {5'h00, s_q.cmd};
        OFF_SECTION_PROTECTION:
        begin
          s_d.rdata[BIT_APP_WP] = s_q.app_wp;
          s_d.rdata[BIT_BOOT_LOCK] = s_q.boot_lock;
        end
        OFF_NVM_STATE:
        begin
          s_d.rdata[BIT_FLASH_BUSY] = flash_busy;
          s_d.rdata[BIT_EEPROM_BUSY] = eeprom_busy;
          s_d.rdata[BIT_WRITE_FAULT] = s_q.fault;
        end
        OFF_IRQ_ENABLE: s_d.rdata[BIT_EEPROM_IDLE] = s_q.irq_en;
        OFF_IRQ_PENDING: s_d.rdata[BIT_EEPROM_IDLE] = s_q.irq_flag;
        OFF_FUSE_VALUE_LO: s_d.rdata = fuse_value_if.value[7:0];
        OFF_FUSE_VALUE_HI: s_d.rdata = fuse_value_if.value[15:8];
        OFF_LAST_LOC_LO: s_d.rdata = loc[7:0];
        OFF_LAST_LOC_HI: s_d.rdata = loc[15:8];
        default: s_d.rdata = RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_q.st <= ST_IDLE;
      s_q.cmd <= CMD_NONE;
      s_q.boot_lock <= 1'b0;
      s_q.lock_active <= 1'b0;
      s_q.app_wp <= 1'b0;
      s_q.fault <= 1'b0;
      s_q.irq_en <= 1'b0;
      s_q.irq_flag <= 1'b0;
      s_q.rdata <= RST_BYTE;
      s_q.start <= 1'b0;
      s_q.target_eeprom <= 1'b0;
      s_q.erase_eeprom <= 1'b0;
      s_q.guard_valid <= 1'b0;
      s_q.guard_data <= RST_WORD;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Read data and the command word show for one cycle only
  assign reg_rdata = s_q.rdata;
  assign nvm_start = s_q.start;
  assign nvm_cmd = s_q.cmd;
  assign nvm_target_eeprom = s_q.target_eeprom;
  assign nvm_erase_eeprom = s_q.erase_eeprom;
  assign fuse_addr = loc;
  assign fuse_data = fuse_value_if.value;
  assign guard_rd_valid = s_q.guard_valid;
  assign guard_rd_data = s_q.guard_data;
  assign eeprom_idle_irq = s_q.irq_en && s_q.irq_flag;
endmodule
`default_nettype wire

// >>> bench/nvc_regs_chk.sv
// Purpose: Port checks for the memory controller registers
// Assumes: One clock domain, core_clk
// Notes: Bound into every nvc_regs
`timescale 1ns/1ps
`default_nettype none
module nvc_regs_chk
  import nvc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Context and array
  input wire logic from_debug_port,
  input wire logic self_program_key,
  input wire logic flash_busy,
  input wire logic eeprom_busy,
  input wire logic eeprom_preserve_fuse,
  // Results
  input wire logic nvm_start,
  input wire logic [2:0] nvm_cmd,
  input wire logic nvm_erase_eeprom,
  input wire logic mem_rd_valid,
  input wire logic [15:0] mem_rd_addr,
  input wire logic [15:0] mem_rd_data,
  input wire logic guard_rd_valid,
  input wire logic [15:0] guard_rd_data,
  input wire logic eeprom_idle_irq
);
  // ------
  // Properties
  // ------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic cmd_wr = reg_wr && reg_addr == OFF_NVM_COMMAND;
  a_no_key: assert property (cmd_wr && !self_program_key |=> !nvm_start)
    else $error("command launched without key");
  a_code_zero: assert property (cmd_wr && reg_wdata[2:0] == 3'h0 |=> !nvm_start)
    else $error("code zero launched");
  a_cpu_fuse: assert property (cmd_wr && reg_wdata[2:0] == 3'h7 && !from_debug_port |=> !nvm_start)
    else $error("fuse command taken from cpu");
  a_cmd_pulse: assert property (nvm_start |=> !nvm_start && nvm_cmd == 3'h0)
    else $error("launch longer than one cycle");
  a_erase_ee: assert property (nvm_start && nvm_cmd == 3'h6 |-> nvm_erase_eeprom)
    else $error("eeprom erase not flagged");
  a_chip_save: assert property (nvm_start && nvm_cmd == 3'h5 |->
    nvm_erase_eeprom == !$past(eeprom_preserve_fuse))
    else $error("full erase ignores preserve fuse");
  a_status_rd: assert property (reg_rd && reg_addr == OFF_NVM_STATE |=>
    reg_rdata[1:0] == {$past(eeprom_busy), $past(flash_busy)} && reg_rdata[7:3] == 5'h00)
    else $error("status read wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 4'h5 |=> reg_rdata == 8'h00)
    else $error("reserved offset not zero");
  a_irq_hold: assert property (eeprom_idle_irq && !eeprom_busy &&
    !(reg_wr && reg_addr == OFF_IRQ_ENABLE) |=> eeprom_idle_irq)
    else $error("idle request dropped");
  a_guard_pass: assert property (mem_rd_valid &&
    (mem_rd_addr < 16'h8000 || mem_rd_addr > 16'h81ff) |=> guard_rd_valid && guard_rd_data == $past(mem_rd_data))
    else $error("read outside boot altered");
endmodule
bind nvc_regs nvc_regs_chk nvc_regs_chk_inst (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .from_debug_port, .self_program_key, .flash_busy, .eeprom_busy, .eeprom_preserve_fuse,
  .nvm_start, .nvm_cmd, .nvm_erase_eeprom, .mem_rd_valid, .mem_rd_addr, .mem_rd_data, .guard_rd_valid,
  .guard_rd_data, .eeprom_idle_irq);
`default_nettype wire

// >>> bench/nvc_array_model.sv
// Purpose: Memory array stand-in that answers launches with busy
// Assumes: Busy length set by the bench per launch
// Notes: Busy rises one cycle after the launch pulse
`timescale 1ns/1ps
`default_nettype none
module nvc_array_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Controller side
  input wire logic nvm_start,
  input wire logic nvm_target_eeprom,
  input wire logic [4:0] busy_len,
  output logic flash_busy,
  output logic eeprom_busy
);
  logic [4:0] cnt_q;
  logic ee_q;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      cnt_q <= 5'h00;
    else if (nvm_start)
      cnt_q <= busy_len;
    else if (cnt_q != 5'h00)
      cnt_q <= cnt_q - 5'h01;
    if (nvm_start)
      ee_q <= nvm_target_eeprom;
  end
  assign flash_busy = cnt_q != 5'h00 && !ee_q;
  assign eeprom_busy = cnt_q != 5'h00 && ee_q;
endmodule
`default_nettype wire

// >>> bench/nvm_controller_registers_test.sv
// Purpose: Self-checking bench for the memory controller registers
// Assumes: Array model answers every launch
// Notes: Reads and launches are checked against queued notes
`timescale 1ns/1ps
`default_nettype none
module nvm_controller_registers_test
  import nvc_pkg::*;
;
  logic core_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, rd_dly = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic from_debug_port = 1'h0, self_program_key = 1'h0, change_protection_unlock = 1'h0;
  logic exec_in_boot = 1'h0, buffer_fill = 1'h0, buffer_section_mix = 1'h0, eeprom_preserve_fuse = 1'h0;
  logic mem_rd_valid = 1'h0;
  logic [15:0] buffer_fill_addr = 16'h0000, mem_rd_addr = 16'h0000, mem_rd_data = 16'h0000, r;
  logic flash_busy, eeprom_busy, nvm_start, nvm_target_eeprom, nvm_erase_eeprom, guard_rd_valid, eeprom_idle_irq;
  logic [2:0] nvm_cmd;
  logic [15:0] fuse_addr, fuse_data, guard_rd_data;
  logic [4:0] busy_len = 5'h0c;
  logic [7:0] rd_q[$];
  logic [2:0] start_q[$];
  int fail_count = 0, samples_checked = 0;
  nvc_regs nvc_regs_inst (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .from_debug_port, .self_program_key, .change_protection_unlock, .exec_in_boot, .flash_busy, .eeprom_busy,
    .buffer_fill, .buffer_fill_addr, .buffer_section_mix, .eeprom_preserve_fuse, .nvm_start, .nvm_cmd,
    .nvm_target_eeprom, .nvm_erase_eeprom, .fuse_addr, .fuse_data, .mem_rd_valid, .mem_rd_addr,
    .mem_rd_data, .guard_rd_valid, .guard_rd_data, .eeprom_idle_irq);
  nvc_array_model nvc_array_model_inst (.core_clk, .rst_b, .nvm_start, .nvm_target_eeprom, .busy_len,
    .flash_busy, .eeprom_busy);
  // ------
  // Tasks
  // ------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
  endtask
  task automatic fill(input logic [15:0] a);
    @(posedge core_clk);
    buffer_fill <= 1'h1;
    buffer_fill_addr <= a;
    @(posedge core_clk);
    buffer_fill <= 1'h0;
  endtask
  task automatic memrd(input logic [15:0] a, input logic [15:0] d, input logic [15:0] e);
    @(posedge core_clk);
    mem_rd_valid <= 1'h1;
    mem_rd_addr <= a;
    mem_rd_data <= d;
    @(posedge core_clk);
    mem_rd_valid <= 1'h0;
    @(negedge core_clk);
    check("guard_rd_data", guard_rd_valid ? guard_rd_data : ~e, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 40 && (flash_busy || eeprom_busy); i++)
      @(posedge core_clk);
    @(posedge core_clk);
  endtask
  task automatic cmd(input logic [2:0] c, input logic go);
    if (go)
      start_q.push_back(c);
    wr(OFF_NVM_COMMAND, {5'h00, c});
    settle();
  endtask
  // ------
  // Monitor and run
  // ------
  initial
    forever #50 core_clk = ~core_clk;
  always @(posedge core_clk)
    rd_dly <= reg_rd;
  always @(negedge core_clk)
  begin
    if (rd_dly)
      check("reg_rdata", {8'h00, reg_rdata}, {8'h00, rd_q.pop_front()});
    if (nvm_start)
      check("nvm_cmd", {13'h0, nvm_cmd}, start_q.size() ? {13'h0, start_q.pop_front()} : 16'hffff);
  end
  initial
  begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    close_out();
  end
  initial
  begin
    r = 16'($urandom(32'h8523a7d9));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    for (int a = 0; a < 10; a++)
      rd(a[3:0], (a == 4) ? 8'h01 : 8'h00);
    r = 16'($urandom);
    wr(OFF_FUSE_VALUE_LO, r[7:0]);
    wr(OFF_FUSE_VALUE_HI, r[15:8]);
    wr(OFF_LAST_LOC_HI, r[7:0]);
    wr(4'h5, r[7:0]);
    wr(OFF_NVM_STATE, 8'hff);
    wr(OFF_IRQ_ENABLE, 8'hfe);
    rd(OFF_FUSE_VALUE_HI, r[15:8]);
    rd(OFF_LAST_LOC_HI, r[7:0]);
    rd(OFF_NVM_STATE, 8'h00);
    rd(OFF_IRQ_ENABLE, 8'h00);
    check("fuse_data", fuse_data, r);
    fill(16'h1423);
    rd(OFF_LAST_LOC_LO, 8'h23);
    check("fuse_addr", fuse_addr, 16'h1423);
    self_program_key <= 1'h1;
    from_debug_port <= 1'h1;
    for (int c = 0; c < 8; c++)
    begin
      eeprom_preserve_fuse <= 1'($urandom);
      busy_len <= 5'($urandom_range(1, 12));
      cmd(c[2:0], c != 0);
    end
    from_debug_port <= 1'h0;
    cmd(3'h7, 1'h0);
    self_program_key <= 1'h0;
    cmd(3'h1, 1'h0);
    self_program_key <= 1'h1;
    rd(OFF_NVM_COMMAND, 8'h00);
    buffer_section_mix <= 1'h1;
    cmd(3'h3, 1'h0);
    rd(OFF_NVM_STATE, 8'h04);
    cmd(3'h2, 1'h1);
    buffer_section_mix <= 1'h0;
    check("target", 16'(nvm_target_eeprom), 16'h0001);
    wr(OFF_SECTION_PROTECTION, 8'hff);
    rd(OFF_SECTION_PROTECTION, 8'h00);
    change_protection_unlock <= 1'h1;
    wr(OFF_SECTION_PROTECTION, 8'hff);
    wr(OFF_SECTION_PROTECTION, 8'h00);
    rd(OFF_SECTION_PROTECTION, 8'h01);
    fill(16'h8400);
    cmd(3'h1, 1'h0);
    rd(OFF_NVM_STATE, 8'h04);
    cmd(3'h4, 1'h1);
    check("target", 16'(nvm_target_eeprom), 16'h0000);
    rd(OFF_NVM_STATE, 8'h00);
    exec_in_boot <= 1'h1;
    wr(OFF_SECTION_PROTECTION, 8'h02);
    rd(OFF_SECTION_PROTECTION, 8'h03);
    r = 16'($urandom);
    memrd(16'h8010, r, r);
    @(posedge core_clk);
    exec_in_boot <= 1'h0;
    @(posedge core_clk);
    memrd(16'h8010, r, 16'h0000);
    memrd(16'h8400, r, r);
    wr(OFF_IRQ_ENABLE, 8'h01);
    wr(OFF_IRQ_PENDING, 8'h01);
    @(negedge core_clk);
    check("irq", 16'(eeprom_idle_irq), 16'h0001);
    fill(16'h1410);
    busy_len <= 5'h10;
    start_q.push_back(3'h2);
    wr(OFF_NVM_COMMAND, 8'h02);
    repeat (3) @(posedge core_clk);
    wr(OFF_IRQ_PENDING, 8'h01);
    @(negedge core_clk);
    check("irq", 16'(eeprom_idle_irq), 16'h0000);
    settle();
    @(negedge core_clk);
    check("irq", 16'(eeprom_idle_irq), 16'h0001);
    check("target", 16'(nvm_target_eeprom), 16'h0001);
    wr(OFF_IRQ_ENABLE, 8'h00);
    @(negedge core_clk);
    check("irq", 16'(eeprom_idle_irq), 16'h0000);
    repeat (2) @(posedge core_clk);
    check("starts left", 16'(start_q.size()), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
